// >>> shared/mrac_pkg.sv
// Constants and types for the region attribute checker.
// Assumes a 32-bit Avalon-MM register port and a 32-bit core address.
package mrac_pkg;
    // Register map
    localparam logic [31:0] ADDR_BASE_SEL = 32'he000ed9c;
    localparam logic [31:0] ALIAS_STEP    = 32'h00000008;
    localparam logic [31:0] ALIAS_SPAN    = 32'h00000020;
    localparam logic [31:0] ADDR_CTRL     = 32'he000edc0;
    localparam logic [31:0] ADDR_STATUS   = 32'he000edc4;

    // Attribute word fields
    localparam int XN_BIT    = 28;
    localparam int AP_LSB    = 24;
    localparam int TEX_LSB   = 19;
    localparam int S_BIT     = 18;
    localparam int C_BIT     = 17;
    localparam int B_BIT     = 16;
    localparam int SRD_LSB   = 8;
    localparam int SIZE_LSB  = 1;
    localparam int EN_BIT    = 0;
    localparam logic [31:0] ATTR_MASK = 32'h173fff3f;

    // Base word fields
    localparam int VALID_BIT = 4;
    localparam int BASE_LSB  = 5;
    localparam int REGION_W  = 4;

    // Size encodings: bytes = 2^(size+1)
    localparam logic [4:0] SIZE_MIN = 5'h04;
    localparam logic [4:0] SIZE_SUB = 5'h07;

    // Status register fields
    localparam int ST_FAULT_BIT  = 0;
    localparam int ST_EXEC_BIT   = 1;
    localparam int ST_REGION_LSB = 4;

    // Reset values
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    localparam logic        CTRL_RESET = 1'b0;

    // Cache policy codes
    localparam logic [1:0] POL_NC     = 2'h0;
    localparam logic [1:0] POL_WB_RWA = 2'h1;
    localparam logic [1:0] POL_WT     = 2'h2;
    localparam logic [1:0] POL_WB_NA  = 2'h3;

    // Access permission codes
    localparam logic [2:0] AP_NONE    = 3'h0;
    localparam logic [2:0] AP_PRIV_RW = 3'h1;
    localparam logic [2:0] AP_USER_RO = 3'h2;
    localparam logic [2:0] AP_FULL    = 3'h3;
    localparam logic [2:0] AP_RSVD    = 3'h4;
    localparam logic [2:0] AP_PRIV_RO = 3'h5;
    localparam logic [2:0] AP_RO      = 3'h6;
    localparam logic [2:0] AP_RO_ALT  = 3'h7;

    typedef enum logic [2:0] {
        MT_STRONG,
        MT_DEVICE,
        MT_NORMAL,
        MT_IMPDEF,
        MT_RESERVED
    } mrac_mem_t;

    typedef struct packed {
        mrac_mem_t  mtype;
        logic       share;
        logic [1:0] inner;
        logic [1:0] outer;
    } mrac_attr_t;
endpackage : mrac_pkg

// >>> rtl/mrac_region_match.sv
// Address match of one protection region, with subregion masking.
// Assumes base and attribute words as held by the register file.
`timescale 1ns/10ps
module mrac_region_match (
    input  wire logic [31:0] base,
    input  wire logic [31:0] attr,
    input  wire logic [31:0] addr,
    output logic             hit
);
    logic [4:0]  size;
    logic [31:0] mask;
    logic [2:0]  sub;
    logic        sub_off;

    always_comb begin
        size = attr[mrac_pkg::SIZE_LSB +: 5];
        mask = 32'hffffffff << ({1'b0, size} + 6'h01);
        sub  = 3'(addr >> (size - 5'h02));
        // Eight subregions only from 256 bytes up
        sub_off = (size >= mrac_pkg::SIZE_SUB) && attr[mrac_pkg::SRD_LSB + 32'(sub)];
        hit = attr[mrac_pkg::EN_BIT]
            && (size >= mrac_pkg::SIZE_MIN)
            && (((addr ^ base) & mask) == 32'h00000000)
            && !sub_off;
    end
endmodule : mrac_region_match

// >>> rtl/mrac_region_check.sv
// Region attribute decode and access checking for a protection unit.
// Assumes core requests and the Avalon-MM master share clk.
//
// Summary of operation
// - Regions of 256 bytes or more split into eight separately maskable subregions.
// - Mask bit set disables subregion; bit 8 lowest address, bit 15 highest.
// - 000/0/0 strongly-ordered shared, 000/0/1 shared device, 010/0/0 unshared device.
// - Normal codes 000/1/0, 000/1/1, 001/0/0, 001/1/1 give equal inner/outer policy.
// - Top type bit set: cached normal, outer from type bits, inner from C,B.
// - Share bit sets shareability for normal memory only; ignored otherwise.
// - Permission 000 faults every access at both privilege levels.
// - 001 privileged read/write only; 011 full read/write for both levels.
// - 010 privileged read/write, unprivileged read only; unprivileged write faults.
// - 101 privileged read only; 110 and 111 read only for both levels.
// - Fetch executes only with read permission and never-execute clear, else fault.
// - Never-execute set forbids execution; clear permits subject to read check.
// - Base/attribute pair at 0xe000ed9c, aliased at +8, +16 and +24 bytes.
// - Base write with valid set through any alias selects named region 0-15.
// - Never-execute bit 28, permission 26:24, type 21:19, S/C/B bits 18/17/16.
// - Region bytes are two to the size field plus one; sizes below 4 reserved.
// - Region enables act only while the unit-wide enable bit is set.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/10ps
module mrac_region_check #(
    parameter int NREG = 16
) (
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire logic [31:0]             avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    input  wire logic [3:0]              avs_byteenable,
    output logic [31:0]                  avs_readdata,
    output logic                         avs_waitrequest,
    input  wire logic                    acc_valid,
    input  wire logic [31:0]             acc_addr,
    input  wire logic                    acc_write,
    input  wire logic                    acc_fetch,
    input  wire logic                    acc_priv,
    output logic                         acc_done,
    output logic                         acc_hit,
    output logic [mrac_pkg::REGION_W-1:0] acc_region,
    output logic                         perm_fault,
    output logic                         memory_management_fault,
    output mrac_pkg::mrac_mem_t          mem_type,
    output logic                         mem_shareable,
    output logic [1:0]                   inner_policy,
    output logic [1:0]                   outer_policy
);
    typedef struct packed {
        logic [NREG-1:0][31:0]         base;
        logic [NREG-1:0][31:0]         attr;
        logic [mrac_pkg::REGION_W-1:0] sel;
        logic                          unit_en;
        logic [31:0]                   status;
        logic                          ack;
        logic [31:0]                   rdata;
        logic                          done;
        logic                          hit;
        logic [mrac_pkg::REGION_W-1:0] region;
        logic                          pfault;
        logic                          mfault;
        mrac_pkg::mrac_attr_t          mattr;
    } mrac_state_t;

    mrac_state_t s_reg;
    mrac_state_t s_next;

    logic [NREG-1:0]               hit_vec;
    logic                          hit_any;
    logic [mrac_pkg::REGION_W-1:0] win;
    logic [31:0]                   win_attr;
    logic [2:0]                    ap;
    logic                          rd_ok;
    logic                          wr_ok;
    logic                          ok;
    logic [31:0]                   off;
    logic                          in_pair;
    logic                          is_attr;
    logic [31:0]                   cur_base;
    logic [31:0]                   cur_attr;
    logic [31:0]                   wmerge;
    logic [mrac_pkg::REGION_W-1:0] tgt;
    logic [31:0]                   st_set;
    logic [31:0]                   st_clr;

    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_match
            mrac_region_match u_match (
                .base (s_reg.base[g]),
                .attr (s_reg.attr[g]),
                .addr (acc_addr),
                .hit  (hit_vec[g])
            );
        end
    endgenerate

    // Byte-lane merge of a write into a held word
    function automatic logic [31:0] merge_be(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction : merge_be

    // Memory type, shareability and policies from type/C/B/S
    function automatic mrac_pkg::mrac_attr_t decode_attr(input logic [31:0] a);
        mrac_pkg::mrac_attr_t r;
        logic [2:0] type_extension_bits;
        logic       c;
        logic       b;
        logic       sh;
        type_extension_bits = a[mrac_pkg::TEX_LSB +: 3];
        c   = a[mrac_pkg::C_BIT];
        b   = a[mrac_pkg::B_BIT];
        sh  = a[mrac_pkg::S_BIT];
        r.mtype = mrac_pkg::MT_RESERVED;
        r.share = 1'b0;
        r.inner = mrac_pkg::POL_NC;
        r.outer = mrac_pkg::POL_NC;
        if (type_extension_bits[2]) begin
            r.mtype = mrac_pkg::MT_NORMAL;
            r.outer = type_extension_bits[1:0];
            r.inner = {c, b};
            r.share = sh;
        end else begin
            unique case ({type_extension_bits[1:0], c, b})
                4'h0: begin
                    r.mtype = mrac_pkg::MT_STRONG;
                    r.share = 1'b1;
                end
                4'h1: begin
                    r.mtype = mrac_pkg::MT_DEVICE;
                    r.share = 1'b1;
                end
                4'h2: begin
                    r.mtype = mrac_pkg::MT_NORMAL;
                    r.inner = mrac_pkg::POL_WT;
                    r.outer = mrac_pkg::POL_WT;
                    r.share = sh;
                end
                4'h3: begin
                    r.mtype = mrac_pkg::MT_NORMAL;
                    r.inner = mrac_pkg::POL_WB_NA;
                    r.outer = mrac_pkg::POL_WB_NA;
                    r.share = sh;
                end
                4'h4: begin
                    r.mtype = mrac_pkg::MT_NORMAL;
                    r.share = sh;
                end
                4'h6: begin
                    r.mtype = mrac_pkg::MT_IMPDEF;
                end
                4'h7: begin
                    r.mtype = mrac_pkg::MT_NORMAL;
                    r.inner = mrac_pkg::POL_WB_RWA;
                    r.outer = mrac_pkg::POL_WB_RWA;
                    r.share = sh;
                end
                4'h8: begin
                    r.mtype = mrac_pkg::MT_DEVICE;
                    r.share = 1'b0;
                end
                default: begin
                    r.mtype = mrac_pkg::MT_RESERVED;
                end
            endcase
        end
        return r;
    endfunction : decode_attr

    // Read permission per privilege level
    function automatic logic read_allowed(input logic [2:0] p, input logic priv);
        logic r;
        unique case (p)
            mrac_pkg::AP_NONE:    r = 1'b0;
            mrac_pkg::AP_PRIV_RW: r = priv;
            mrac_pkg::AP_USER_RO: r = 1'b1;
            mrac_pkg::AP_FULL:    r = 1'b1;
            mrac_pkg::AP_RSVD:    r = 1'b0;
            mrac_pkg::AP_PRIV_RO: r = priv;
            mrac_pkg::AP_RO:      r = 1'b1;
            mrac_pkg::AP_RO_ALT:  r = 1'b1;
        endcase
        return r;
    endfunction : read_allowed

    // Write permission per privilege level
    function automatic logic write_allowed(input logic [2:0] p, input logic priv);
        logic r;
        unique case (p)
            mrac_pkg::AP_PRIV_RW: r = priv;
            mrac_pkg::AP_USER_RO: r = priv;
            mrac_pkg::AP_FULL:    r = 1'b1;
            default:              r = 1'b0;
        endcase
        return r;
    endfunction : write_allowed

    // Highest numbered matching region wins
    always_comb begin
        hit_any = 1'b0;
        win     = '0;
        for (int i = 0; i < NREG; i++) begin
            if (hit_vec[i]) begin
                hit_any = 1'b1;
                win     = i[mrac_pkg::REGION_W-1:0];
            end
        end
    end

    always_comb begin
        win_attr = s_reg.attr[win];
        ap       = win_attr[mrac_pkg::AP_LSB +: 3];
        rd_ok    = read_allowed(ap, acc_priv);
        wr_ok    = write_allowed(ap, acc_priv);
        if (acc_fetch) begin
            ok = rd_ok && !win_attr[mrac_pkg::XN_BIT];
        end else if (acc_write) begin
            ok = wr_ok;
        end else begin
            ok = rd_ok;
        end
    end

    // Register decode over the base/attribute pair and its aliases
    always_comb begin
        off      = avs_address - mrac_pkg::ADDR_BASE_SEL;
        in_pair  = (off < mrac_pkg::ALIAS_SPAN) && (off[1:0] == 2'h0);
        is_attr  = off[2];
        cur_base = s_reg.base[s_reg.sel];
        cur_attr = s_reg.attr[s_reg.sel];
        wmerge   = merge_be(is_attr ? cur_attr : cur_base, avs_writedata, avs_byteenable);
        tgt      = avs_writedata[mrac_pkg::REGION_W-1:0];
    end

    always_comb begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        st_set      = 32'h00000000;
        st_clr      = 32'h00000000;

        // Access check, one cycle from request to result
        if (acc_valid) begin
            s_next.done = 1'b1;
            if (!s_reg.unit_en) begin
                s_next.hit          = 1'b0;
                s_next.region       = '0;
                s_next.pfault       = 1'b0;
                s_next.mfault       = 1'b0;
                s_next.mattr        = '0;
                s_next.mattr.mtype  = mrac_pkg::MT_NORMAL;
            end else begin
                s_next.hit    = hit_any;
                s_next.region = win;
                s_next.mattr  = decode_attr(win_attr);
                s_next.pfault = hit_any && !(acc_fetch ? rd_ok : ok);
                s_next.mfault = !hit_any || !ok;
                if (!hit_any || !ok) begin
                    st_set[mrac_pkg::ST_FAULT_BIT] = 1'b1;
                    st_set[mrac_pkg::ST_EXEC_BIT]  = acc_fetch;
                    st_set[mrac_pkg::ST_REGION_LSB +: mrac_pkg::REGION_W] = win;
                end
            end
        end

        // Avalon-MM slave: one wait cycle, then answer
        if ((avs_read || avs_write) && !s_reg.ack) begin
            s_next.ack   = 1'b1;
            s_next.rdata = 32'h00000000;
            if (!avs_read) begin
                s_next.rdata = s_reg.rdata;
            end else if (in_pair && is_attr) begin
                s_next.rdata = cur_attr;
            end else if (in_pair) begin
                s_next.rdata = {cur_base[31:mrac_pkg::BASE_LSB], 1'b0, s_reg.sel};
            end else if (avs_address == mrac_pkg::ADDR_CTRL) begin
                s_next.rdata = {31'h00000000, s_reg.unit_en};
            end else if (avs_address == mrac_pkg::ADDR_STATUS) begin
                s_next.rdata = s_reg.status;
            end
        end else if ((avs_read || avs_write) && s_reg.ack) begin
            s_next.ack = 1'b0;
            if (avs_write && in_pair && is_attr) begin
                s_next.attr[s_reg.sel] = wmerge & mrac_pkg::ATTR_MASK;
            end else if (avs_write && in_pair) begin
                if (avs_byteenable[0] && avs_writedata[mrac_pkg::VALID_BIT]) begin
                    s_next.sel       = tgt;
                    s_next.base[tgt] = {wmerge[31:mrac_pkg::BASE_LSB], 5'h00};
                end else begin
                    s_next.base[s_reg.sel] = {wmerge[31:mrac_pkg::BASE_LSB], 5'h00};
                end
            end else if (avs_write && avs_address == mrac_pkg::ADDR_CTRL) begin
                if (avs_byteenable[0]) begin
                    s_next.unit_en = avs_writedata[0];
                end
            end else if (avs_write && avs_address == mrac_pkg::ADDR_STATUS) begin
                if (avs_byteenable[0]) begin
                    st_clr[mrac_pkg::ST_FAULT_BIT] = avs_writedata[mrac_pkg::ST_FAULT_BIT];
                    st_clr[mrac_pkg::ST_EXEC_BIT]  = avs_writedata[mrac_pkg::ST_EXEC_BIT];
                end
            end
        end else begin
            s_next.ack = 1'b0;
        end

        // Sticky flags: a new fault wins over a clear
        s_next.status[1:0] = (s_reg.status[1:0] & ~st_clr[1:0]) | st_set[1:0];
        if (st_set[mrac_pkg::ST_FAULT_BIT]) begin
            s_next.status[mrac_pkg::ST_REGION_LSB +: mrac_pkg::REGION_W] =
                st_set[mrac_pkg::ST_REGION_LSB +: mrac_pkg::REGION_W];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_reg         <= '0;
            s_reg.unit_en <= mrac_pkg::CTRL_RESET;
            s_reg.status  <= mrac_pkg::RESET_WORD;
            s_reg.rdata   <= mrac_pkg::RESET_WORD;
        end else begin
            s_reg <= s_next;
        end
    end

    assign avs_readdata = s_reg.rdata;
    assign avs_waitrequest = !s_reg.ack;
    assign acc_done = s_reg.done;
    assign acc_hit = s_reg.hit;
    assign acc_region = s_reg.region;
    assign perm_fault = s_reg.pfault;
    assign memory_management_fault = s_reg.mfault;
    assign mem_type = s_reg.mattr.mtype;
    assign mem_shareable = s_reg.mattr.share;
    assign inner_policy = s_reg.mattr.inner;
    assign outer_policy = s_reg.mattr.outer;
endmodule : mrac_region_check

// >>> bench/mrac_core_model.sv
// Core side model: issues loads, stores and fetches on the access port.
// Assumes the bench calls issue() from one process, on clk.
`timescale 1ns/10ps
module mrac_core_model (
    input  wire logic        clk,
    output logic             acc_valid,
    output logic [31:0]      acc_addr,
    output logic             acc_write,
    output logic             acc_fetch,
    output logic             acc_priv
);
    logic held;
    initial begin
        acc_valid = 1'b0;
        acc_addr  = 32'h0;
        acc_write = 1'b0;
        acc_fetch = 1'b0;
        acc_priv  = 1'b0;
        held      = 1'b0;
    end
    // Kind 0 load, 1 store, 2 fetch; hold keeps valid up for a follower
    task automatic issue(input logic [31:0] a, input logic [1:0] kd, input logic pr,
                         input logic hold, input logic [1:0] gap);
        if (!held) repeat (gap) @(posedge clk);
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_addr  <= a;
        acc_write <= kd == 2'h1;
        acc_fetch <= kd == 2'h2;
        acc_priv  <= pr;
        held = hold;
        if (!hold) begin
            @(posedge clk);
            acc_valid <= 1'b0;
            acc_addr  <= ~a;
        end
    endtask : issue
endmodule : mrac_core_model

// >>> bench/mrac_region_check_props.sv
// Port checker for the region attribute checker.
// Assumes one clock domain; tracks the unit enable from bus writes.
`timescale 1ns/10ps
module mrac_chk #(parameter int NREG = 16) (
    input wire logic [31:0]          avs_address, avs_writedata, avs_readdata, acc_addr,
    input wire logic                 clk, nrst, avs_read, avs_write, avs_waitrequest,
    input wire logic [3:0]           avs_byteenable,
    input wire logic                 acc_valid, acc_write, acc_fetch, acc_priv, acc_done,
    input wire logic                 acc_hit, perm_fault, memory_management_fault,
    input wire logic [mrac_pkg::REGION_W-1:0] acc_region,
    input wire mrac_pkg::mrac_mem_t  mem_type,
    input wire logic                 mem_shareable,
    input wire logic [1:0]           inner_policy, outer_policy
);
    logic en_reg;
    logic en_next;
    always_comb begin
        en_next = en_reg;
        if (avs_write && !avs_waitrequest && avs_address == mrac_pkg::ADDR_CTRL
            && avs_byteenable[0]) en_next = avs_writedata[0];
    end
    always_ff @(posedge clk) begin
        en_reg <= nrst ? en_next : 1'b0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence bus_req_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence bus_ack_s;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    bus_wait_a: assert property (bus_req_s |=> bus_ack_s)
        else $error("bus answer not one wait cycle");
    rd_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data moved");
    done_lat_a: assert property (acc_valid |=> acc_done)
        else $error("access result late");
    done_pulse_a: assert property (!acc_valid |=> !acc_done)
        else $error("spurious access result");
    result_hold_a: assert property (!acc_valid |=> $stable({acc_hit, acc_region, perm_fault,
        memory_management_fault, mem_type, mem_shareable, inner_policy, outer_policy}))
        else $error("result changed without access");
    off_attr_a: assert property (acc_done && !$past(en_reg) |-> !acc_hit
        && !memory_management_fault && mem_type == mrac_pkg::MT_NORMAL && !mem_shareable
        && inner_policy == 2'h0 && outer_policy == 2'h0) else $error("disabled unit acted");
    nohit_fault_a: assert property (acc_done && $past(en_reg) && !acc_hit
        |-> memory_management_fault && !perm_fault) else $error("miss without fault");
    perm_mmf_a: assert property (acc_done && perm_fault |-> memory_management_fault && acc_hit)
        else $error("permission fault not reported");
    strong_share_a: assert property (acc_done && mem_type == mrac_pkg::MT_STRONG
        |-> mem_shareable) else $error("strongly ordered not shareable");
endmodule : mrac_chk
bind mrac_region_check mrac_chk #(.NREG(NREG)) u_chk (.*);

// >>> bench/mrac_region_check_tb_top.sv
// Bench for the region attribute checker: bus master, core model, scoreboard.
// Assumes the package constants and a one-wait-cycle register bus.
`timescale 1ns/10ps
module mrac_region_check_tb_top;
    logic clk, nrst, avs_read, avs_write, avs_waitrequest, acc_valid, acc_write, acc_fetch;
    logic acc_priv, acc_done, acc_hit, perm_fault, memory_management_fault, mem_shareable;
    logic [31:0] avs_address, avs_writedata, avs_readdata, acc_addr, rnd;
    logic [3:0] avs_byteenable, acc_region;
    logic [1:0] inner_policy, outer_policy;
    mrac_pkg::mrac_mem_t mem_type;
    logic [31:0] rq[$];
    logic [29:0] aq[$], ae;
    int errors, num_checks;
    localparam logic [31:0] B15 = 32'h00040000;
    localparam logic [31:0] AB = mrac_pkg::ADDR_BASE_SEL;
    localparam logic [2:0] NRM = 3'(mrac_pkg::MT_NORMAL);
    mrac_region_check #(.NREG(16)) DUT (.*);
    mrac_core_model u_core (.*);
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    // Attribute word, 1 KiB region, enabled; code is {type, c, b, s}
    function automatic logic [31:0] mk(input logic xn, input logic [2:0] ap,
                                       input logic [5:0] k, input logic [7:0] subregion_disable_mask);
        return {3'h0, xn, 1'b0, ap, 2'h0, k[5:3], k[0], k[2:1], subregion_disable_mask, 2'h0, 5'h09, 1'b1};
    endfunction : mk
    // {mask, type, share, inner, outer}
    function automatic logic [15:0] attr_exp(input logic [5:0] k);
        if (k[5]) return {8'hff, NRM, k[0], k[2:1], k[4:3]};
        case (k[5:1])
            5'h00: return {8'hf0, 3'(mrac_pkg::MT_STRONG), 5'h10};
            5'h01: return {8'hf0, 3'(mrac_pkg::MT_DEVICE), 5'h10};
            5'h08: return {8'hf0, 3'(mrac_pkg::MT_DEVICE), 5'h00};
            5'h02: return {8'hff, NRM, k[0], {2{mrac_pkg::POL_WT}}};
            5'h03: return {8'hff, NRM, k[0], {2{mrac_pkg::POL_WB_NA}}};
            5'h04: return {8'hff, NRM, k[0], {2{mrac_pkg::POL_NC}}};
            5'h07: return {8'hff, NRM, k[0], {2{mrac_pkg::POL_WB_RWA}}};
            5'h06: return {8'he0, 3'(mrac_pkg::MT_IMPDEF), 5'h00};
            default: return {8'he0, 3'(mrac_pkg::MT_RESERVED), 5'h00};
        endcase
    endfunction : attr_exp
    // {perm_fault, any fault}
    function automatic logic [1:0] perm_exp(input logic [2:0] ap, input logic pr,
                                            input logic [1:0] kd, input logic xn);
        logic rd, wr, pf;
        rd = (ap == 3'h1 || ap == 3'h5) ? pr : (ap == 3'h2 || ap == 3'h3 || ap[2:1] == 2'h3);
        wr = ap == 3'h3 || (pr && (ap == 3'h1 || ap == 3'h2));
        pf = (kd == 2'h1) ? !wr : !rd;
        return {pf, pf || (kd == 2'h2 && xn)};
    endfunction : perm_exp
    task automatic cmp(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
        num_checks++;
        if ((g & m) !== (e & m)) begin
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
            errors++;
        end
    endtask : cmp
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 50) begin
            errors++;
            report_and_stop();
        end
        avs_write     <= 1'b0;
        avs_read      <= 1'b0;
        avs_address   <= ~a;
        avs_writedata <= ~d;
    endtask : bus
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic acc(input logic [31:0] a, input logic [1:0] kd, input logic pr,
                       input logic hb, input logic [14:0] e, input logic [14:0] m);
        aq.push_back({m, e});
        rnd = xs(rnd);
        u_core.issue(a, kd, pr, hb && rnd[0], rnd[2:1]);
    endtask : acc
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0)
            cmp(avs_readdata, (rq.size() != 0) ? rq.pop_front() : 32'hx, 32'hffffffff);
        if (acc_done === 1'b1) begin
            ae = (aq.size() != 0) ? aq.pop_front() : {15'h7fff, 15'hx};
            cmp({acc_hit, acc_region, perm_fault, memory_management_fault, 3'(mem_type),
                 mem_shareable, inner_policy, outer_policy}, ae[14:0], ae[29:15]);
        end
    end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        logic [15:0] ea;
        logic [5:0] k;
        nrst = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 32'h0;
        avs_writedata = 32'h0; avs_byteenable = 4'hf; rnd = 32'h07448903;
        errors = 0;
        num_checks = 0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd(AB, 32'h0);
        rd(AB + 32'h4, 32'h0);
        rd(mrac_pkg::ADDR_CTRL, 32'h0);
        rd(32'he000ed00, 32'h0);
        acc(32'h2000, 2'h0, 1'b0, 1'b0, {7'h0, NRM, 5'h0}, 15'h43ff);
        bus(1'b1, mrac_pkg::ADDR_CTRL, 32'h1);
        acc(32'h2000, 2'h0, 1'b1, 1'b0, 15'h0100, 15'h4300);
        for (int j = 0; j < 4; j++) begin
            rnd = xs(rnd);
            bus(1'b1, AB + 8 * j, B15 * (j + 1) / 4 | 32'h10 | 4 * j + 3);
            bus(1'b1, AB + 8 * j + 4, mk(1'b0, 3'h3, 6'h08, 8'h0));
            rd(AB + 8 * j, B15 * (j + 1) / 4 | 4 * j + 3);
            acc(B15 * (j + 1) / 4 + rnd[9:0], 2'h0, 1'b0, 1'b0,
                {1'b1, 4'(4 * j + 3), 10'h0}, 15'h7c00);
        end
        for (int c = 0; c < 32; c++) begin
            rnd = xs(rnd);
            k = {5'(c), rnd[3]};
            ea = attr_exp(k);
            bus(1'b1, AB + 32'h4, mk(1'b0, 3'h3, k, 8'h0));
            acc(B15 + rnd[9:0], 2'h0, 1'b1, 1'b0, {7'h7c, ea[7:0]}, {7'h7f, ea[15:8]});
        end
        for (int a = 0; a < 16; a++) begin
            bus(1'b1, AB + 32'h4, mk(a[3], a[2:0], 6'h08, 8'h0));
            for (int p = 0; p < 6; p++) begin
                rnd = xs(rnd);
                acc(B15 + rnd[9:0], 2'(p % 3), p > 2, p != 5,
                    {5'h1f, perm_exp(a[2:0], p > 2, 2'(p % 3), a[3]), 8'h0},
                    15'h7f00);
            end
        end
        for (int s = 0; s < 8; s++) begin
            rnd = xs(rnd);
            bus(1'b1, AB + 32'h4, mk(1'b0, 3'h3, 6'h08, 8'h1 << s));
            acc(B15 + 128 * s + rnd[6:0], 2'h0, 1'b1, 1'b0, 15'h0100, 15'h4300);
            acc(B15 + 128 * ((s + 1) % 8) + rnd[6:0], 2'h1, 1'b1, 1'b0, 15'h7c00, 15'h7f00);
        end
        rd(AB + 32'h1c, mk(1'b0, 3'h3, 6'h08, 8'h80));
        repeat (4) @(posedge clk);
        if (aq.size() != 0 || rq.size() != 0) errors++;
        report_and_stop();
    end
endmodule : mrac_region_check_tb_top
